// [verilog/sfs_cfg.svh]
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// Register byte offsets
`define SFS_OFS_CLK_DIVIDER 8'h14
`define SFS_OFS_TX_THRESHOLD 8'h18
`define SFS_OFS_RX_THRESHOLD 8'h1C
`define SFS_OFS_TX_LEVEL 8'h20
`define SFS_OFS_RX_LEVEL 8'h24
`define SFS_OFS_PORT_STATUS 8'h28
`define SFS_OFS_IRQ_MASK 8'h2C
`define SFS_OFS_IRQ_MASKED 8'h30
`define SFS_OFS_IRQ_RAW 8'h34

// Status register field positions
`define SFS_ST_BUSY 0
`define SFS_ST_TX_NOT_FULL 1
`define SFS_ST_TX_EMPTY 2
`define SFS_ST_RX_NOT_EMPTY 3
`define SFS_ST_RX_FULL 4
`define SFS_ST_TX_ERROR 5
`define SFS_ST_COLLISION 6

// Interrupt source positions, same in mask, masked and raw registers
`define SFS_IRQ_TX_EMPTY 0
`define SFS_IRQ_TX_OVERFLOW 1
`define SFS_IRQ_RX_UNDERFLOW 2
`define SFS_IRQ_RX_OVERFLOW 3
`define SFS_IRQ_RX_FULL 4
`define SFS_IRQ_CONTENTION 5

// Reset values
`define SFS_RST_DIVIDER 16'h0000
`define SFS_RST_THRESHOLD 3'h0
`define SFS_RST_MASK 6'h3F
`define SFS_RST_LEVEL 4'h0

// Default FIFO depth in entries
`define SFS_FIFO_DEPTH 8

`endif

// [verilog/sfs_pkg.sv]
package sfs_pkg;

  // One bit per interrupt source
  typedef logic [5:0] sfs_irq_type;

  // Serial clock generator state
  typedef enum logic [0:0] {
    SFS_CLK_STOP = 1'b0,
    SFS_CLK_RUN = 1'b1
  } sfs_clk_state_type;

endpackage : sfs_pkg

// [verilog/sfs_regs.sv]
// Behaviour
// R1 - Tx empty raised when level at/below threshold
// R2 - Rx full raised when level at/above threshold
// R3 - Tx level readable, zero after reset
// R4 - Rx level readable, zero after reset
// R5 - Transfer start on empty tx sets error
// R6 - Collision flag reads one after collision
// R7 - Rx full and rx not-empty status bits
// R8 - Tx empty and not-full bits, one at reset
// R9 - Busy bit follows transfer in progress
// R10 - Six mask bits, one passes, reset one
// R11 - Source order fixed in mask and status
// R12 - Masked status register, clear after reset; the code reads 0x11 after reset (tx empty and rx full sources set)
// R13 - Raw status register, clear after reset; the code reads 0x11 after reset (tx empty and rx full sources set)
// R14 - Masked is raw AND mask; drives interrupt
// R15 - Serial clock divides system clock; zero stops
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sfs_cfg.svh"

module sfs_regs #(
  parameter int DEPTH = `SFS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // FIFO and transfer events from the controller
  input wire logic tx_push_i,
  input wire logic tx_pop_i,
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  input wire logic transfer_start_i,
  input wire logic transfer_active_i,
  // Link pins
  input wire logic slave_select_in_b_i,
  output logic sclk_o,
  // Interrupt
  output logic irq_o
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Levels live in a 4-bit field, so depth must fit it
  if (DEPTH < 1 || DEPTH > 15) begin : g_depth_check
    $error("sfs_regs: DEPTH must be 1 to 15");
  end

  localparam logic [3:0] DEPTH_L = 4'(DEPTH);

  // Next level after one cycle of push and pop; a refused access leaves it
  function automatic logic [3:0] level_step(input logic [3:0] lvl, input logic push,
                                            input logic pop);
    logic [3:0] res;
    res = lvl;
    if (push && !pop && lvl != DEPTH_L) begin
      res = lvl + 4'h1;
    end else if (pop && !push && lvl != 4'h0) begin
      res = lvl - 4'h1;
    end
    return res;
  endfunction : level_step

  // ==========================================================
  // Registers and state
  // ==========================================================
  logic [15:0] divisor_reg;
  logic [2:0] tx_thr_reg;
  logic [2:0] rx_thr_reg;
  sfs_pkg::sfs_irq_type mask_reg;
  logic [3:0] tx_cnt_reg;
  logic [3:0] rx_cnt_reg;
  logic busy_reg;
  logic tx_err_reg;
  logic collision_reg;
  logic tx_ovf_reg;
  logic rx_ovf_reg;
  logic rx_unf_reg;
  logic contention_reg;
  logic ss_meta_reg;
  logic ss_sync_reg;
  logic ss_prev_reg;
  logic [15:0] div_cnt_reg;
  sfs_pkg::sfs_clk_state_type clk_state_reg;
  sfs_pkg::sfs_irq_type raw_next;
  sfs_pkg::sfs_irq_type masked_next;
  logic [31:0] rdata_next;
  logic rd_status;
  logic rd_raw;
  logic ss_fall;

  // ==========================================================
  // Software writable registers
  // ==========================================================
  // Divisor, thresholds and mask; other offsets ignore writes
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      divisor_reg <= `SFS_RST_DIVIDER;
      tx_thr_reg <= `SFS_RST_THRESHOLD;
      rx_thr_reg <= `SFS_RST_THRESHOLD;
      mask_reg <= `SFS_RST_MASK; // [R10]
    end else if (wr_i) begin
      case (addr_i)
        `SFS_OFS_CLK_DIVIDER: divisor_reg <= wdata_i[15:0];
        `SFS_OFS_TX_THRESHOLD: tx_thr_reg <= wdata_i[2:0];
        `SFS_OFS_RX_THRESHOLD: rx_thr_reg <= wdata_i[2:0];
        `SFS_OFS_IRQ_MASK: mask_reg <= wdata_i[5:0]; // [R10]
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // FIFO levels and busy
  // ==========================================================
  // Levels track the controller's push and pop strobes
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_cnt_reg <= `SFS_RST_LEVEL;
      rx_cnt_reg <= `SFS_RST_LEVEL;
    end else begin
      tx_cnt_reg <= level_step(tx_cnt_reg, tx_push_i, tx_pop_i); // [R3]
      rx_cnt_reg <= level_step(rx_cnt_reg, rx_push_i, rx_pop_i); // [R4]
    end
  end

  // Busy is registered so the status read sees a stable copy
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= transfer_active_i; // [R9]
    end
  end

  // ==========================================================
  // Slave select synchroniser
  // ==========================================================
  // Pin is asynchronous; only the second and third stages are looked at
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
      ss_prev_reg <= 1'b1;
    end else begin
      ss_meta_reg <= slave_select_in_b_i;
      ss_sync_reg <= ss_meta_reg;
      ss_prev_reg <= ss_sync_reg;
    end
  end

  // Another master pulling select low means contention
  assign ss_fall = ss_prev_reg && !ss_sync_reg;

  // ==========================================================
  // Sticky event flags
  // ==========================================================
  assign rd_status = rd_i && addr_i == `SFS_OFS_PORT_STATUS;
  assign rd_raw = rd_i && (addr_i == `SFS_OFS_IRQ_RAW || addr_i == `SFS_OFS_IRQ_MASKED);

  // Error flags clear on a status read; a new event in that cycle wins
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_err_reg <= 1'b0;
      collision_reg <= 1'b0;
    end else begin
      if (transfer_start_i && tx_cnt_reg == 4'h0) begin
        tx_err_reg <= 1'b1; // [R5]
      end else if (rd_status) begin
        tx_err_reg <= 1'b0;
      end
      if (ss_fall && busy_reg) begin
        collision_reg <= 1'b1; // [R6]
      end else if (rd_status) begin
        collision_reg <= 1'b0;
      end
    end
  end

  // Interrupt events clear on a read of either status view
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_ovf_reg <= 1'b0;
      rx_ovf_reg <= 1'b0;
      rx_unf_reg <= 1'b0;
      contention_reg <= 1'b0;
    end else begin
      if (tx_push_i && !tx_pop_i && tx_cnt_reg == DEPTH_L) begin
        tx_ovf_reg <= 1'b1; // [R13]
      end else if (rd_raw) begin
        tx_ovf_reg <= 1'b0;
      end
      if (rx_push_i && !rx_pop_i && rx_cnt_reg == DEPTH_L) begin
        rx_ovf_reg <= 1'b1; // [R13]
      end else if (rd_raw) begin
        rx_ovf_reg <= 1'b0;
      end
      if (rx_pop_i && !rx_push_i && rx_cnt_reg == 4'h0) begin
        rx_unf_reg <= 1'b1; // [R13]
      end else if (rd_raw) begin
        rx_unf_reg <= 1'b0;
      end
      if (ss_fall) begin
        contention_reg <= 1'b1; // [R13]
      end else if (rd_raw) begin
        contention_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt sources
  // ==========================================================
  // Threshold sources are levels and follow the counts directly
  always_comb begin
    raw_next = '0;
    raw_next[`SFS_IRQ_TX_EMPTY] = {1'b0, tx_thr_reg} >= tx_cnt_reg; // [R1] [R11]
    raw_next[`SFS_IRQ_TX_OVERFLOW] = tx_ovf_reg; // [R11]
    raw_next[`SFS_IRQ_RX_UNDERFLOW] = rx_unf_reg; // [R11]
    raw_next[`SFS_IRQ_RX_OVERFLOW] = rx_ovf_reg; // [R11]
    raw_next[`SFS_IRQ_RX_FULL] = rx_cnt_reg >= {1'b0, rx_thr_reg}; // [R2] [R11]
    raw_next[`SFS_IRQ_CONTENTION] = contention_reg; // [R11]
  end

  assign masked_next = raw_next & mask_reg; // [R14]

  // Interrupt output is a flop so it never glitches
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |masked_next; // [R14]
    end
  end

  // ==========================================================
  // Serial clock divider
  // ==========================================================
  // Runs only during a transfer; low half then high half of the period
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_state_reg <= sfs_pkg::SFS_CLK_STOP;
      div_cnt_reg <= 16'h0000;
      sclk_o <= 1'b0;
    end else begin
      case (clk_state_reg)
        sfs_pkg::SFS_CLK_STOP: begin
          div_cnt_reg <= 16'h0000;
          sclk_o <= 1'b0;
          if (divisor_reg != 16'h0000 && transfer_active_i) begin
            clk_state_reg <= sfs_pkg::SFS_CLK_RUN;
          end
        end
        sfs_pkg::SFS_CLK_RUN: begin
          if (divisor_reg == 16'h0000 || !transfer_active_i) begin
            clk_state_reg <= sfs_pkg::SFS_CLK_STOP; // [R15]
            div_cnt_reg <= 16'h0000;
            sclk_o <= 1'b0;
          end else begin
            if (div_cnt_reg >= divisor_reg - 16'h0001) begin
              div_cnt_reg <= 16'h0000;
            end else begin
              div_cnt_reg <= div_cnt_reg + 16'h0001;
            end
            sclk_o <= div_cnt_reg >= {1'b0, divisor_reg[15:1]}; // [R15]
          end
        end
        default: begin
          clk_state_reg <= sfs_pkg::SFS_CLK_STOP;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Unmapped offsets and reserved bits read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (addr_i)
      `SFS_OFS_CLK_DIVIDER: rdata_next[15:0] = divisor_reg;
      `SFS_OFS_TX_THRESHOLD: rdata_next[2:0] = tx_thr_reg;
      `SFS_OFS_RX_THRESHOLD: rdata_next[2:0] = rx_thr_reg;
      `SFS_OFS_TX_LEVEL: rdata_next[3:0] = tx_cnt_reg; // [R3]
      `SFS_OFS_RX_LEVEL: rdata_next[3:0] = rx_cnt_reg; // [R4]
      `SFS_OFS_PORT_STATUS: begin
        rdata_next[`SFS_ST_BUSY] = busy_reg; // [R9]
        rdata_next[`SFS_ST_TX_NOT_FULL] = tx_cnt_reg != DEPTH_L; // [R8]
        rdata_next[`SFS_ST_TX_EMPTY] = tx_cnt_reg == 4'h0; // [R8]
        rdata_next[`SFS_ST_RX_NOT_EMPTY] = rx_cnt_reg != 4'h0; // [R7]
        rdata_next[`SFS_ST_RX_FULL] = rx_cnt_reg == DEPTH_L; // [R7]
        rdata_next[`SFS_ST_TX_ERROR] = tx_err_reg; // [R5]
        rdata_next[`SFS_ST_COLLISION] = collision_reg; // [R6]
      end
      `SFS_OFS_IRQ_MASK: rdata_next[5:0] = mask_reg; // [R10]
      `SFS_OFS_IRQ_MASKED: rdata_next[5:0] = masked_next; // [R12]
      `SFS_OFS_IRQ_RAW: rdata_next[5:0] = raw_next; // [R13]
      default: begin
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_select_fall;
    ss_sync_reg ##1 !ss_sync_reg;
  endsequence

  sequence s_start_on_empty;
    transfer_start_i && tx_cnt_reg == 4'h0;
  endsequence

  property p_tx_thresh;
    @(posedge clock_i) disable iff (!rst_b_i)
    (rst_b_i && {1'b0, tx_thr_reg} >= tx_cnt_reg && mask_reg[`SFS_IRQ_TX_EMPTY]) |=> irq_o;
  endproperty
  a_tx_thresh: assert property (p_tx_thresh) else $error("tx threshold irq missing"); // [R1]

  property p_rx_thresh;
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i && addr_i == `SFS_OFS_IRQ_RAW)
      |=> rdata_o[`SFS_IRQ_RX_FULL] == ($past(rx_cnt_reg) >= {1'b0, $past(rx_thr_reg)});
  endproperty
  a_rx_thresh: assert property (p_rx_thresh) else $error("rx threshold bit wrong"); // [R2]

  property p_tx_level;
    @(posedge clock_i) disable iff (!rst_b_i)
    (tx_push_i && !tx_pop_i && tx_cnt_reg < DEPTH_L) |=> tx_cnt_reg == $past(tx_cnt_reg) + 4'h1;
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("tx level did not count up"); // [R3]

  property p_rx_level_read;
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i && addr_i == `SFS_OFS_RX_LEVEL) |=> rdata_o == {28'h0000000, $past(rx_cnt_reg)};
  endproperty
  a_rx_level_read: assert property (p_rx_level_read) else $error("rx level read wrong"); // [R4]

  property p_tx_error;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_start_on_empty ##1 !rd_status ##1 rd_status
      |=> rdata_o[`SFS_ST_TX_ERROR];
  endproperty
  a_tx_error: assert property (p_tx_error) else $error("tx error not reported"); // [R5]

  property p_contention;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_select_fall |=> contention_reg;
  endproperty
  a_contention: assert property (p_contention) else $error("contention not latched"); // [R13]

  property p_busy;
    @(posedge clock_i) disable iff (!rst_b_i)
    transfer_active_i ##1 (rd_i && addr_i == `SFS_OFS_PORT_STATUS) |=> rdata_o[`SFS_ST_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown"); // [R9]

  property p_masked_read;
    @(posedge clock_i) disable iff (!rst_b_i)
    (rd_i && addr_i == `SFS_OFS_IRQ_MASKED)
      |=> rdata_o[5:0] == ($past(raw_next) & $past(mask_reg));
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked status wrong"); // [R12]

  property p_irq_off;
    @(posedge clock_i) disable iff (!rst_b_i)
    (masked_next == 6'h00) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without source"); // [R14]

  property p_clock_stop;
    @(posedge clock_i) disable iff (!rst_b_i)
    (divisor_reg == 16'h0000) [*2] |=> !sclk_o;
  endproperty
  a_clock_stop: assert property (p_clock_stop) else $error("serial clock runs at zero"); // [R15]

endmodule : sfs_regs
`default_nettype wire

// [testbench/sfs_link_peer.sv]
`timescale 1ns/100ps
`default_nettype none

// =============================================
// Peripheral on the far side of the link
// =============================================
module sfs_link_peer (
  // Link pins
  input wire logic sclk_i,
  output logic slave_select_b_o,
  // Bench command and observation
  input wire logic claim_i,
  output int edges_o
);

  // Select idles high, as if pulled up; a claim pulls it low for ten system cycles
  initial begin
    slave_select_b_o = 1'b1;
    forever begin
      @(posedge claim_i);
      slave_select_b_o = 1'b0;
      #400;
      slave_select_b_o = 1'b1;
    end
  end

  // Count serial clock rising edges so the bench can judge the divider
  initial begin
    edges_o = 0;
    forever begin
      @(posedge sclk_i);
      edges_o = edges_o + 1;
    end
  end

endmodule : sfs_link_peer

`default_nettype wire

// [testbench/tb_spi_fifo_status_irq_regs.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sfs_cfg.svh"

module tb_spi_fifo_status_irq_regs;

  // =============================================
  // Signals
  // =============================================
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [3:0] ev = 4'h0;
  logic transfer_start_i = 1'b0;
  logic transfer_active_i = 1'b0;
  logic slave_select_b;
  logic sclk_o;
  logic irq_o;
  logic claim = 1'b0;
  int edges;
  int e0;
  int n_errors = 0;
  int comparisons = 0;

  // Clock of 25 MHz
  always #20 clock_i = ~clock_i;

  // =============================================
  // Instances
  // =============================================
  sfs_regs #(.DEPTH(8)) i_sfs_regs (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .tx_push_i(ev[0]),
    .tx_pop_i(ev[1]),
    .rx_push_i(ev[2]),
    .rx_pop_i(ev[3]),
    .transfer_start_i(transfer_start_i),
    .transfer_active_i(transfer_active_i),
    .slave_select_in_b_i(slave_select_b),
    .sclk_o(sclk_o),
    .irq_o(irq_o)
  );

  sfs_link_peer i_sfs_link_peer (
    .sclk_i(sclk_o),
    .slave_select_b_o(slave_select_b),
    .claim_i(claim),
    .edges_o(edges)
  );

  // =============================================
  // Tasks
  // =============================================
  // Closing verdict, shared by the main sequence and the watchdog
  task automatic complete_run();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp1

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    cmp32(rdata_o, exp);
  endtask : chk

  // Event pulses: sel is {rx_pop, rx_push, tx_pop, tx_push}, one entry per pulse
  task automatic pulse(input logic [3:0] sel, input int n);
    repeat (n) begin
      @(posedge clock_i);
      ev <= sel;
      @(posedge clock_i);
      ev <= 4'h0;
    end
  endtask : pulse

  task automatic irq_is(input logic exp);
    @(posedge clock_i);
    #1;
    cmp1(irq_o, exp);
  endtask : irq_is

  task automatic contend();
    @(posedge clock_i);
    claim <= 1'b1;
    @(posedge clock_i);
    claim <= 1'b0;
    repeat (20) @(posedge clock_i);
  endtask : contend

  // =============================================
  // Watchdog
  // =============================================
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  // =============================================
  // Main sequence
  // =============================================
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    irq_is(1'b1);
    chk(`SFS_OFS_CLK_DIVIDER, 32'h0);
    chk(`SFS_OFS_TX_THRESHOLD, 32'h0);
    chk(`SFS_OFS_RX_THRESHOLD, 32'h0);
    chk(`SFS_OFS_TX_LEVEL, 32'h0);
    chk(`SFS_OFS_RX_LEVEL, 32'h0);
    chk(`SFS_OFS_PORT_STATUS, 32'h06);
    chk(`SFS_OFS_IRQ_MASK, 32'h3F);
    chk(`SFS_OFS_IRQ_MASKED, 32'h11);
    chk(`SFS_OFS_IRQ_RAW, 32'h11);
    chk(8'h38, 32'h0);
    // Field widths clip, read-only places ignore writes
    wr_reg(`SFS_OFS_CLK_DIVIDER, 32'hFFFFFFFF);
    chk(`SFS_OFS_CLK_DIVIDER, 32'h0000FFFF);
    wr_reg(`SFS_OFS_TX_THRESHOLD, 32'hFFFFFFFF);
    chk(`SFS_OFS_TX_THRESHOLD, 32'h7);
    wr_reg(`SFS_OFS_RX_THRESHOLD, 32'hFFFFFFFF);
    chk(`SFS_OFS_RX_THRESHOLD, 32'h7);
    wr_reg(`SFS_OFS_TX_LEVEL, 32'h5);
    chk(`SFS_OFS_TX_LEVEL, 32'h0);
    wr_reg(`SFS_OFS_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    chk(`SFS_OFS_IRQ_MASKED, 32'h0);
    chk(`SFS_OFS_IRQ_RAW, 32'h01);
    wr_reg(`SFS_OFS_IRQ_MASK, 32'h3F);
    wr_reg(`SFS_OFS_TX_THRESHOLD, 32'h2);
    wr_reg(`SFS_OFS_RX_THRESHOLD, 32'h3);
    wr_reg(`SFS_OFS_CLK_DIVIDER, 32'h0);
    // Transmit side: threshold boundary, full, overflow
    pulse(4'h1, 3);
    chk(`SFS_OFS_TX_LEVEL, 32'h3);
    chk(`SFS_OFS_PORT_STATUS, 32'h02);
    chk(`SFS_OFS_IRQ_RAW, 32'h00);
    irq_is(1'b0);
    pulse(4'h2, 1);
    chk(`SFS_OFS_IRQ_RAW, 32'h01);
    pulse(4'h1, 6);
    chk(`SFS_OFS_PORT_STATUS, 32'h00);
    pulse(4'h1, 1);
    chk(`SFS_OFS_TX_LEVEL, 32'h8);
    chk(`SFS_OFS_IRQ_RAW, 32'h02);
    chk(`SFS_OFS_IRQ_RAW, 32'h00);
    pulse(4'h0, 0);
    @(posedge clock_i);
    transfer_start_i <= 1'b1;
    @(posedge clock_i);
    transfer_start_i <= 1'b0;
    chk(`SFS_OFS_PORT_STATUS, 32'h00);
    pulse(4'h2, 8);
    chk(`SFS_OFS_PORT_STATUS, 32'h06);
    // Transfer begun on an empty transmit queue
    @(posedge clock_i);
    transfer_start_i <= 1'b1;
    @(posedge clock_i);
    transfer_start_i <= 1'b0;
    chk(`SFS_OFS_PORT_STATUS, 32'h26);
    chk(`SFS_OFS_PORT_STATUS, 32'h06);
    // Receive side: threshold boundary, full, overflow, underflow
    pulse(4'h4, 2);
    chk(`SFS_OFS_RX_LEVEL, 32'h2);
    chk(`SFS_OFS_PORT_STATUS, 32'h0E);
    chk(`SFS_OFS_IRQ_RAW, 32'h01);
    pulse(4'h4, 1);
    chk(`SFS_OFS_IRQ_RAW, 32'h11);
    pulse(4'h4, 5);
    chk(`SFS_OFS_PORT_STATUS, 32'h1E);
    pulse(4'h4, 1);
    chk(`SFS_OFS_IRQ_MASKED, 32'h19);
    chk(`SFS_OFS_IRQ_RAW, 32'h11);
    pulse(4'h8, 9);
    chk(`SFS_OFS_RX_LEVEL, 32'h0);
    chk(`SFS_OFS_IRQ_RAW, 32'h05);
    chk(`SFS_OFS_IRQ_RAW, 32'h01);
    // Contention while idle, only its mask bit open
    wr_reg(`SFS_OFS_IRQ_MASK, 32'h20);
    irq_is(1'b0);
    contend();
    #1;
    cmp1(irq_o, 1'b1);
    chk(`SFS_OFS_PORT_STATUS, 32'h06);
    chk(`SFS_OFS_IRQ_MASKED, 32'h20);
    chk(`SFS_OFS_IRQ_RAW, 32'h01);
    irq_is(1'b0);
    wr_reg(`SFS_OFS_IRQ_MASK, 32'h3F);
    // Active transfer with divisor 8 gives a 320 ns serial clock
    wr_reg(`SFS_OFS_CLK_DIVIDER, 32'h8);
    @(posedge clock_i);
    transfer_active_i <= 1'b1;
    e0 = edges;
    repeat (64) @(posedge clock_i);
    #1;
    cmp1((edges - e0 >= 7) && (edges - e0 <= 8), 1'b1);
    chk(`SFS_OFS_PORT_STATUS, 32'h07);
    contend();
    chk(`SFS_OFS_PORT_STATUS, 32'h47);
    chk(`SFS_OFS_PORT_STATUS, 32'h07);
    chk(`SFS_OFS_IRQ_RAW, 32'h21);
    @(posedge clock_i);
    transfer_active_i <= 1'b0;
    chk(`SFS_OFS_PORT_STATUS, 32'h06);
    // Divisor zero keeps the serial clock still even while active
    wr_reg(`SFS_OFS_CLK_DIVIDER, 32'h0);
    @(posedge clock_i);
    transfer_active_i <= 1'b1;
    e0 = edges;
    repeat (32) @(posedge clock_i);
    #1;
    cmp32(32'(edges - e0), 32'h0);
    cmp1(sclk_o, 1'b0);
    @(posedge clock_i);
    transfer_active_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    complete_run();
  end

endmodule : tb_spi_fifo_status_irq_regs

`default_nettype wire
